// ===== rtl/pwp_pkg.sv
// package: register map, field layout and reset values of the write-protect block
package pwp_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_CLEAR = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_SET = 4'h4;
   // group 0 flag positions
   localparam int G0_EXT_IRQ = 6;
   localparam int G0_RT_COUNTER = 5;
   localparam int G0_WATCHDOG = 4;
   localparam int G0_CLOCK_GEN = 3;
   localparam int G0_SYS_CTRL = 2;
   localparam int G0_POWER_MGR = 1;
   localparam logic [DATA_W-1:0] G0_MASK = 32'h0000007E;
   localparam logic [DATA_W-1:0] G0_RESET = 32'h00000000;
   // group 1 flag positions
   localparam int G1_TRACE_BUF = 6;
   localparam int G1_IO_PORT = 3;
   localparam int G1_FLASH_CTRL = 2;
   localparam int G1_DEBUG_SVC = 1;
   localparam logic [DATA_W-1:0] G1_MASK = 32'h0000004E;
   localparam logic [DATA_W-1:0] G1_RESET = 32'h00000002;

   typedef struct packed {
      logic sel;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pwp_req_t;

   typedef struct packed {
      logic ready;
      logic slverr;
      logic [DATA_W-1:0] rdata;
   } pwp_rsp_t;
endpackage : pwp_pkg

// ===== rtl/pwp_protect.sv
// module: per-peripheral write-protect flags for two peripheral groups
`timescale 1ns/1ps
// How it works
// - writing zero to a flag bit leaves that flag as it was
// - writing one to a clear register bit removes that peripheral's protection
// - a read returns 1 for protected, 0 for unprotected
// - group 0 clear register at 0x00, resets to 0x000000
// - group 0 bits: ext irq 6, rt counter 5, watchdog 4, clock 3, sysctl 2, power 1
// - group 1 clear register at 0x00, resets to 0x000002 (debug unit protected)
// - group 1 bits: trace 6, io port 3, flash 2, debug 1; others unused
// - group 1 set register at 0x04, same layout, reads 0x000002 after reset
// - a blocked flag drops writes to that peripheral on the same bridge
// - debugger accesses ignore protection and always pass

module pwp_protect
   import pwp_pkg::*;
(
   input wire logic clk,                   // bus clock, 200 MHz
   input wire logic rst_n,                 // synchronous reset, active low
   input wire pwp_req_t g0_req,            // group 0 register request
   input wire pwp_req_t g1_req,            // group 1 register request
   output pwp_rsp_t g0_rsp,                // group 0 response, registered
   output pwp_rsp_t g1_rsp,                // group 1 response, registered
   input wire logic [DATA_W-1:0] g0_pwr,   // group 0 per-peripheral write attempts
   input wire logic [DATA_W-1:0] g1_pwr,   // group 1 per-peripheral write attempts
   input wire logic dbg_access,            // access comes from the debugger
   output logic [DATA_W-1:0] g0_prot,      // group 0 protection flags
   output logic [DATA_W-1:0] g1_prot,      // group 1 protection flags
   output logic [DATA_W-1:0] g0_allow,     // group 0 write allowed per peripheral
   output logic [DATA_W-1:0] g1_allow      // group 1 write allowed per peripheral
);

   // ------------------------------------------------------------
   // flag state
   // ------------------------------------------------------------
   logic [DATA_W-1:0] next_g0_prot;
   logic [DATA_W-1:0] next_g1_prot;
   logic g0_wr;
   logic g1_wr;

   always_comb begin
      g0_wr = g0_req.sel && g0_req.write;
      g1_wr = g1_req.sel && g1_req.write;
      next_g0_prot = g0_prot;
      next_g1_prot = g1_prot;
      // group 0 has only the clear view in this map
      if (g0_wr && g0_req.addr == OFS_CLEAR) begin
         next_g0_prot = g0_prot & ~(g0_req.wdata & G0_MASK);
      end
      if (g1_wr && g1_req.addr == OFS_CLEAR) begin
         next_g1_prot = g1_prot & ~(g1_req.wdata & G1_MASK);
      end else if (g1_wr && g1_req.addr == OFS_SET) begin
         next_g1_prot = g1_prot | (g1_req.wdata & G1_MASK);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         g0_prot <= G0_RESET;
         g1_prot <= G1_RESET;
      end else begin
         g0_prot <= next_g0_prot;
         g1_prot <= next_g1_prot;
      end
   end

   // ------------------------------------------------------------
   // register read and response
   // ------------------------------------------------------------
   pwp_rsp_t next_g0_rsp;
   pwp_rsp_t next_g1_rsp;

   always_comb begin
      next_g0_rsp = '0;
      next_g1_rsp = '0;
      next_g0_rsp.ready = g0_req.sel;
      next_g1_rsp.ready = g1_req.sel;
      // a write answers too, with the flags as they stood before it
      if (g0_req.sel) begin
         if (g0_req.addr == OFS_CLEAR) begin
            next_g0_rsp.rdata = g0_prot;
         end else begin
            next_g0_rsp.slverr = 1'b1;
         end
      end
      if (g1_req.sel) begin
         // both views return the one stored flag set
         if (g1_req.addr == OFS_CLEAR || g1_req.addr == OFS_SET) begin
            next_g1_rsp.rdata = g1_prot;
         end else begin
            next_g1_rsp.slverr = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         g0_rsp <= '0;
         g1_rsp <= '0;
      end else begin
         g0_rsp <= next_g0_rsp;
         g1_rsp <= next_g1_rsp;
      end
   end

   // ------------------------------------------------------------
   // write gating toward the peripherals
   // ------------------------------------------------------------
   // registered so outputs come from flops; costs one cycle of latency
   logic [DATA_W-1:0] next_g0_allow;
   logic [DATA_W-1:0] next_g1_allow;

   always_comb begin
      next_g0_allow = g0_pwr & (dbg_access ? '1 : ~g0_prot);
      next_g1_allow = g1_pwr & (dbg_access ? '1 : ~g1_prot);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         g0_allow <= '0;
         g1_allow <= '0;
      end else begin
         g0_allow <= next_g0_allow;
         g1_allow <= next_g1_allow;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_zero_keeps: assert property (@(posedge clk) disable iff (!rst_n)
      (g1_req.sel && g1_req.write && g1_req.wdata == '0) |=> g1_prot == $past(g1_prot))
      else $error("zero write changed group 1 flags");
   a_clear_bit: assert property (@(posedge clk) disable iff (!rst_n)
      (g0_req.sel && g0_req.write && g0_req.addr == OFS_CLEAR) |=> (g0_prot & $past(g0_req.wdata)) == '0)
      else $error("clear left a group 0 flag set");
   a_read_flags: assert property (@(posedge clk) disable iff (!rst_n)
      (g0_req.sel && !g0_req.write && g0_req.addr == OFS_CLEAR) |=> g0_rsp.rdata == $past(g0_prot))
      else $error("group 0 read does not show flags");
   a_g0_unused: assert property (@(posedge clk) disable iff (!rst_n)
      (g0_prot & ~G0_MASK) == '0)
      else $error("unused group 0 bit set");
   a_g1_unused: assert property (@(posedge clk) disable iff (!rst_n)
      (g1_prot & ~G1_MASK) == '0)
      else $error("unused group 1 bit set");
   a_reset_value: assert property (@(posedge clk) !rst_n |=> g1_prot == G1_RESET && g0_prot == G0_RESET)
      else $error("wrong reset flags");
   a_set_bit: assert property (@(posedge clk) disable iff (!rst_n)
      (g1_req.sel && g1_req.write && g1_req.addr == OFS_SET) |=> (($past(g1_req.wdata) & G1_MASK) & ~g1_prot) == '0)
      else $error("set did not protect");
   a_views_same: assert property (@(posedge clk) disable iff (!rst_n)
      (g1_req.sel && !g1_req.write && g1_req.addr == OFS_SET) |=> g1_rsp.rdata == $past(g1_prot))
      else $error("set view differs from flags");
   a_block_write: assert property (@(posedge clk) disable iff (!rst_n)
      !dbg_access |=> (g1_allow & $past(g1_prot)) == '0)
      else $error("protected write passed");
   a_dbg_bypass: assert property (@(posedge clk) disable iff (!rst_n)
      dbg_access |=> g0_allow == $past(g0_pwr))
      else $error("debugger write blocked");

   // ------------------------------------------------------------
   // checks on both groups, the bus answer and the gate
   // ------------------------------------------------------------
   // group 0 flags reset to zero and can only fall, so its gate checks always see open bits
   a_g0_zero_keeps: assert property (@(posedge clk) disable iff (!rst_n)
      (g0_req.sel && g0_req.write && g0_req.wdata == '0) |=> g0_prot == $past(g0_prot))
      else $error("zero write changed group 0 flags");
   a_set_keeps: assert property (@(posedge clk) disable iff (!rst_n)
      (g1_req.sel && g1_req.write && g1_req.addr == OFS_SET)
      |=> (g1_prot & ~$past(g1_req.wdata)) == ($past(g1_prot) & ~$past(g1_req.wdata)))
      else $error("set write touched a flag written as zero");
   a_g1_clear_bit: assert property (@(posedge clk) disable iff (!rst_n)
      (g1_req.sel && g1_req.write && g1_req.addr == OFS_CLEAR) |=> (g1_prot & $past(g1_req.wdata)) == '0)
      else $error("clear left a group 1 flag set");
   a_g1_read_flags: assert property (@(posedge clk) disable iff (!rst_n)
      (g1_req.sel && !g1_req.write && g1_req.addr == OFS_CLEAR) |=> g1_rsp.rdata == $past(g1_prot))
      else $error("group 1 read does not show flags");
   a_g0_offset: assert property (@(posedge clk) disable iff (!rst_n)
      (g0_req.sel && g0_req.addr != OFS_CLEAR) |=> g0_rsp.slverr && g0_prot == $past(g0_prot))
      else $error("group 0 answered outside its register");
   a_g1_offset: assert property (@(posedge clk) disable iff (!rst_n)
      (g1_req.sel && g1_req.addr != OFS_CLEAR && g1_req.addr != OFS_SET)
      |=> g1_rsp.slverr && g1_prot == $past(g1_prot))
      else $error("group 1 answered outside its registers");
   a_write_rdata: assert property (@(posedge clk) disable iff (!rst_n)
      (g1_req.sel && g1_req.write && g1_req.addr == OFS_SET) |=> g1_rsp.rdata == $past(g1_prot))
      else $error("set view answer differs from flags");

   // the answer is a single-cycle pulse; a held select would read as a second access
   a_ready_g0: assert property (@(posedge clk) disable iff (!rst_n)
      g0_req.sel |=> g0_rsp.ready)
      else $error("group 0 access not answered");
   a_ready_g1: assert property (@(posedge clk) disable iff (!rst_n)
      g1_req.sel |=> g1_rsp.ready)
      else $error("group 1 access not answered");
   a_pulse_g0: assert property (@(posedge clk) disable iff (!rst_n)
      !g0_req.sel |=> !g0_rsp.ready)
      else $error("group 0 answer without access");
   a_pulse_g1: assert property (@(posedge clk) disable iff (!rst_n)
      !g1_req.sel |=> !g1_rsp.ready)
      else $error("group 1 answer without access");

   // the debugger bypass only opens the gate; the flags themselves are untouched
   a_g0_block: assert property (@(posedge clk) disable iff (!rst_n)
      !dbg_access |=> (g0_allow & $past(g0_prot)) == '0)
      else $error("protected group 0 write passed");
   a_gate_exact: assert property (@(posedge clk) disable iff (!rst_n)
      !dbg_access |=> g1_allow == ($past(g1_pwr) & ~$past(g1_prot)))
      else $error("group 1 gate wrong");
   a_g0_gate_exact: assert property (@(posedge clk) disable iff (!rst_n)
      !dbg_access |=> g0_allow == ($past(g0_pwr) & ~$past(g0_prot)))
      else $error("group 0 gate wrong");
   a_g1_dbg_bypass: assert property (@(posedge clk) disable iff (!rst_n)
      dbg_access |=> g1_allow == $past(g1_pwr))
      else $error("debugger write blocked in group 1");

endmodule : pwp_protect

// ===== verification/pwp_host.sv
// bus master model that drives both register ports
`timescale 1ns/1ps
module pwp_host
   import pwp_pkg::*;
(
   input wire logic clk, // bus clock
   input wire pwp_rsp_t g0_rsp, // group 0 answer
   input wire pwp_rsp_t g1_rsp, // group 1 answer
   output pwp_req_t g0_req, // group 0 request
   output pwp_req_t g1_req // group 1 request
);
   initial g0_req = '0;
   initial g1_req = '0;
   // ----------------------------------------
   // one access
   // ----------------------------------------
   // sel is dropped at the taking edge, since holding it would start a second access
   task automatic acc(input logic g, wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output pwp_rsp_t r);
      @(posedge clk);
      if (g) g1_req <= '{1'b1, wr, a, d};
      else g0_req <= '{1'b1, wr, a, d};
      @(posedge clk);
      if (g) g1_req <= '0;
      else g0_req <= '0;
      // the answer is registered: ready is sampled high one edge later
      @(posedge clk);
      r = g ? g1_rsp : g0_rsp;
   endtask : acc
endmodule : pwp_host

// ===== verification/pwp_protect_bench.sv
// self-checking bench of the write-protect block
`timescale 1ns/1ps
module pwp_protect_bench;
   import pwp_pkg::*;
   logic clk = 0, rst_n = 0, dbg_access = 0;
   logic [DATA_W-1:0] g0_pwr = '0, g1_pwr = '0, g0_prot, g1_prot, g0_allow, g1_allow;
   logic [DATA_W-1:0] e0 = G0_RESET, e1 = G1_RESET;
   pwp_req_t g0_req, g1_req;
   pwp_rsp_t g0_rsp, g1_rsp, r;
   logic [15:0] s = 16'h8666;
   int fails = 0, n_checks = 0;
   initial forever #2.5 clk = ~clk;
   pwp_protect dut (.clk(clk), .rst_n(rst_n), .g0_req(g0_req), .g1_req(g1_req), .g0_rsp(g0_rsp),
      .g1_rsp(g1_rsp), .g0_pwr(g0_pwr), .g1_pwr(g1_pwr), .dbg_access(dbg_access), .g0_prot(g0_prot),
      .g1_prot(g1_prot), .g0_allow(g0_allow), .g1_allow(g1_allow));
   pwp_host host (.clk(clk), .g0_rsp(g0_rsp), .g1_rsp(g1_rsp), .g0_req(g0_req), .g1_req(g1_req));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   function automatic logic [DATA_W-1:0] upd(input logic [DATA_W-1:0] c, d, m, input logic set);
      return set ? (c | (d & m)) : (c & ~(d & m));
   endfunction : upd
   task automatic cmp_rsp(input pwp_rsp_t got, exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: bus answer got %h want %h", $time, got, exp);
      end
   endtask : cmp_rsp
   task automatic cmp_prot(input logic [DATA_W-1:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s flags got %h want %h", $time, what, got, exp);
      end
   endtask : cmp_prot
   task automatic cmp_allow(input logic [DATA_W-1:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s gate got %h want %h", $time, what, got, exp);
      end
   endtask : cmp_allow
   task automatic go(input logic g, wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic err;
      logic [DATA_W-1:0] old;
      err = g ? (a != OFS_CLEAR && a != OFS_SET) : (a != OFS_CLEAR);
      old = g ? e1 : e0;
      host.acc(g, wr, a, d, r);
      if (wr && !err) begin
         if (g) e1 = upd(e1, d, G1_MASK, a == OFS_SET);
         else e0 = upd(e0, d, G0_MASK, 1'b0);
      end
      // a write answers with the flags as they stood before it
      cmp_rsp(r, {1'h1, err, err ? 32'h0 : old});
      cmp_prot(g0_prot, e0, "group 0");
      cmp_prot(g1_prot, e1, "group 1");
   endtask : go
   // allow follows the attempts one cycle later
   task automatic gate;
      @(posedge clk);
      s = lfsr(s);
      g0_pwr <= {s, lfsr(s)};
      g1_pwr <= {lfsr(s), s};
      dbg_access <= s[3];
      @(posedge clk);
      #1;
      cmp_allow(g0_allow, g0_pwr & (~e0 | {DATA_W{dbg_access}}), "group 0");
      cmp_allow(g1_allow, g1_pwr & (~e1 | {DATA_W{dbg_access}}), "group 1");
   endtask : gate
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      go(0, 0, OFS_CLEAR, 32'h0);
      go(1, 0, OFS_CLEAR, 32'h0);
      go(1, 0, OFS_SET, 32'h0);
      gate();
      go(1, 1, OFS_SET, 32'hFFFFFFFF);
      go(1, 0, OFS_CLEAR, 32'h0);
      go(1, 1, OFS_CLEAR, 32'h00000004);
      go(0, 1, OFS_CLEAR, 32'hFFFFFFFF);
      go(0, 1, OFS_SET, 32'hFFFFFFFF);
      go(1, 1, 4'h8, 32'hFFFFFFFF);
      repeat (60) begin
         s = lfsr(s);
         go(s[0], s[1], {s[3:2], 2'b00}, {lfsr(s), s});
         gate();
      end
      complete_run();
   end
   initial begin
      #20000;
      fails++;
      complete_run();
   end
endmodule : pwp_protect_bench
